/* File: rtl/sptw_cfg.svh */
// constants for the supervision timer: offsets, fields, resets and timing
`ifndef SPTW_CFG_SVH
`define SPTW_CFG_SVH

// ----------------------------------------------------------------
// register offsets and fields
// ----------------------------------------------------------------
`define SPTW_OPTION_ADDR    8'h81
`define SPTW_OPTION_RESET   8'hff
`define SPTW_ASSIGN_BIT     3
`define SPTW_PS_MSB         2
`define SPTW_CFG_ADDR       14'h2007
`define SPTW_TEST_LO        14'h2000
`define SPTW_TEST_HI        14'h3fff
`define SPTW_CFG_ENABLE_BIT 2
`define SPTW_CFG_ERASED     14'h3fff

// ----------------------------------------------------------------
// timing: internal oscillator period and nominal time-out
// ----------------------------------------------------------------
`define SPTW_CLK_PERIOD_NS  4
`define SPTW_OSC_PERIOD_NS  1000
`define SPTW_OSC_CYCLES     (`SPTW_OSC_PERIOD_NS / `SPTW_CLK_PERIOD_NS)
`define SPTW_TIMEOUT_MS     18
`define SPTW_TIMEOUT_TICKS  ((`SPTW_TIMEOUT_MS * 1000000) / `SPTW_OSC_PERIOD_NS)

`endif

/* File: rtl/sptw_pkg.sv */
// types shared by the supervision timer files
package sptw_pkg;

  // ----------------------------------------------------------------
  // core power state as seen by the timer
  // ----------------------------------------------------------------
  typedef enum logic {
    st_run,
    st_sleep
  } sptw_state_t;

endpackage : sptw_pkg

/* File: rtl/sptw_prescaler.sv */
// shared prescaler: ripple count with a selectable power-of-two tap
`timescale 1ns/10ps

module sptw_prescaler #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       reset,
  // count control
  input  wire logic       clear,
  input  wire logic       in_tick,
  input  wire logic [3:0] shift,
  // divided tick
  output logic            out_tick
);

  logic [WIDTH-1:0] count;
  logic [WIDTH-1:0] next_count;
  logic [WIDTH-1:0] mask;

  // ----------------------------------------------------------------
  // counter
  // ----------------------------------------------------------------
  // clear beats a tick so a restart never leaks an early output
  always_comb begin
    mask       = ~({WIDTH{1'b1}} << shift);
    next_count = count;
    if (clear) begin
      next_count = '0;
    end else if (in_tick) begin
      next_count = count + {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end

  // a shift of n passes one tick in 2**n
  assign out_tick = in_tick && !clear && ((count & mask) == mask);

  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);

  ratio_one_pass_a : assert property (  // see (RQ6)
    (shift == 4'h0 && in_tick && !clear) |-> out_tick)
    else $error("ratio 1:1 did not pass the tick");

  ratio_two_skip_a : assert property (  // see (RQ6)
    (shift == 4'h1 && out_tick) |=> (!out_tick))
    else $error("ratio 1:2 passed two ticks in a row");

endmodule : sptw_prescaler

/* File: rtl/sptw_top.sv */
// supervision timer with sleep and wake control, option and config word
`timescale 1ns/10ps
`include "sptw_cfg.svh"

// Functional notes
// (RQ1) timer runs from its own free oscillator tick, unaffected by sleep
// (RQ2) expiry while running requests a full device reset
// (RQ3) expiry while asleep wakes the device instead of resetting
// (RQ4) config word bit 2 enables the timer; zero disables it for good
// (RQ5) base time-out is nominally 18 ms without prescaler
// (RQ6) option register can hand the prescaler over, up to 1:128
// (RQ7) clear and sleep instructions zero timer and its assigned prescaler
// (RQ8) every expiry clears the active-low time-out status bit
// (RQ9) sleep with a pending enabled interrupt acts as no-operation
// (RQ10) interrupt during or after sleep wakes at once after sleep completes
// (RQ11) interrupt wake ignores the global interrupt enable
// (RQ12) software should issue the clear instruction right before sleep
// (RQ13) config word at 2007h; programmed bits read 0, erased read 1
// (RQ14) space 2000h to 3FFFh reachable only in programming mode
// (RQ15) assignment bit set gives prescaler to timer, clear to timer module
// (RQ16) time-out and power-down bits survive a master clear
// (RQ17) counter plus optional prescaler gives a one-cycle time-out pulse
module sptw_top #(
  parameter int OSC_CYCLES    = `SPTW_OSC_CYCLES,
  parameter int TIMEOUT_TICKS = `SPTW_TIMEOUT_TICKS,
  parameter int IRQ_SOURCES   = 4
) (
  // clock and power-on reset
  input  wire logic                   core_clk,
  input  wire logic                   reset,
  // pins
  input  wire logic                   master_clear_n,
  input  wire logic                   prog_mode_pin,
  // instructions from the core
  input  wire logic                   timer_clear_instr,
  input  wire logic                   sleep_instr,
  // interrupt sources
  input  wire logic [IRQ_SOURCES-1:0] irq_enable,
  input  wire logic [IRQ_SOURCES-1:0] irq_flag,
  input  wire logic                   global_irq_enable,
  // option register port
  input  wire logic                   reg_wr_en,
  input  wire logic [7:0]             reg_addr,
  input  wire logic [7:0]             reg_wdata,
  output logic      [7:0]             reg_rdata,
  output logic      [7:0]             option_value,
  // program space port for the config word
  input  wire logic                   cfg_rd_en,
  input  wire logic                   cfg_wr_en,
  input  wire logic [13:0]            cfg_addr,
  input  wire logic [13:0]            cfg_wdata,
  output logic      [13:0]            cfg_rdata,
  // timer module prescaler path
  input  wire logic                   tmod_src_tick,
  output logic                        tmod_tick,
  // status and power control
  output logic                        timeout_status_n,
  output logic                        powerdown_status_n,
  output logic                        core_halt,
  output logic                        wake_pulse,
  output logic                        wake_to_isr,
  output logic                        expiry_reset_pulse
);

  localparam int OW = $clog2(OSC_CYCLES + 1);
  localparam int TW = $clog2(TIMEOUT_TICKS + 1);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic mclear_sync1;
  logic mclear_n_s;
  logic prog_sync1;
  logic prog_mode;

  // first stages feed only the second stages
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      mclear_sync1 <= 1'b1;
      mclear_n_s   <= 1'b1;
      prog_sync1 <= 1'b0;
      prog_mode  <= 1'b0;
    end else begin
      mclear_sync1 <= master_clear_n;
      mclear_n_s   <= mclear_sync1;
      prog_sync1 <= prog_mode_pin;
      prog_mode  <= prog_sync1;
    end
  end

  // ----------------------------------------------------------------
  // option register and config word
  // ----------------------------------------------------------------
  logic        [13:0]       cfg_word;
  logic        [13:0]       next_cfg_word;
  logic        [7:0]        next_option;
  logic        [7:0]        next_reg_rdata;
  logic        [13:0]       next_cfg_rdata;
  logic                     soft_rst;
  logic                     in_test_space;
  logic                     ps_to_timer;
  logic                     timer_enable;

  assign in_test_space = (cfg_addr >= `SPTW_TEST_LO) && (cfg_addr <= `SPTW_TEST_HI);
  assign ps_to_timer   = option_value[`SPTW_ASSIGN_BIT];
  assign timer_enable  = cfg_word[`SPTW_CFG_ENABLE_BIT];  // see (RQ4)

  // programming only clears bits, so a disabled timer stays disabled
  always_comb begin
    next_option    = option_value;
    next_cfg_word  = cfg_word;
    next_reg_rdata = (reg_addr == `SPTW_OPTION_ADDR) ? option_value : 8'h00;
    next_cfg_rdata = 14'h0000;
    if (soft_rst) begin
      next_option = `SPTW_OPTION_RESET;
    end else if (reg_wr_en && reg_addr == `SPTW_OPTION_ADDR) begin
      next_option = reg_wdata;  // see (RQ6) (RQ15)
    end
    if (prog_mode && in_test_space) begin  // see (RQ14)
      if (cfg_rd_en && cfg_addr == `SPTW_CFG_ADDR) begin
        next_cfg_rdata = cfg_word;
      end
      if (cfg_wr_en && cfg_addr == `SPTW_CFG_ADDR) begin
        next_cfg_word = cfg_word & cfg_wdata;  // see (RQ13)
      end
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      option_value <= `SPTW_OPTION_RESET;
      cfg_word     <= `SPTW_CFG_ERASED;
      reg_rdata    <= 8'h00;
      cfg_rdata    <= 14'h0000;
    end else begin
      option_value <= next_option;
      cfg_word     <= next_cfg_word;
      reg_rdata    <= next_reg_rdata;
      cfg_rdata    <= next_cfg_rdata;
    end
  end

  // ----------------------------------------------------------------
  // oscillator tick and base counter
  // ----------------------------------------------------------------
  logic [OW-1:0] osc_cnt;
  logic [OW-1:0] next_osc_cnt;
  logic [TW-1:0] base_cnt;
  logic [TW-1:0] next_base_cnt;
  logic          osc_tick;
  logic          timer_clr;
  logic          base_expire;
  logic          psc_out;
  logic          timeout_pulse;
  logic          irq_pending;
  sptw_pkg::sptw_state_t state;

  // free running, never gated by sleep or reset requests
  assign osc_tick    = (osc_cnt == OW'(OSC_CYCLES - 1));  // see (RQ1)
  assign irq_pending = |(irq_enable & irq_flag);          // see (RQ11)
  assign timer_clr   = timer_clear_instr
                    || (sleep_instr && state == sptw_pkg::st_run && !irq_pending);  // see (RQ7)
  assign base_expire = timer_enable && !soft_rst && !timer_clr && osc_tick
                    && (base_cnt == TW'(TIMEOUT_TICKS - 1));  // see (RQ5)

  always_comb begin
    next_osc_cnt  = osc_tick ? '0 : osc_cnt + OW'(1);
    next_base_cnt = base_cnt;
    if (soft_rst || timer_clr || !timer_enable || base_expire) begin
      next_base_cnt = '0;
    end else if (osc_tick) begin
      next_base_cnt = base_cnt + TW'(1);
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      osc_cnt  <= '0;
      base_cnt <= '0;
    end else begin
      osc_cnt  <= next_osc_cnt;
      base_cnt <= next_base_cnt;
    end
  end

  // prescaler follows the counter when assigned, else feeds timer module
  sptw_prescaler #(
    .WIDTH (8)
  ) u_prescaler (
    .core_clk (core_clk),
    .reset    (reset),
    .clear    (soft_rst || (ps_to_timer && timer_clr)),         // see (RQ7)
    .in_tick  (ps_to_timer ? base_expire : tmod_src_tick),      // see (RQ15)
    .shift    ({1'b0, option_value[`SPTW_PS_MSB:0]} + {3'b000, !ps_to_timer}),
    .out_tick (psc_out)
  );

  assign timeout_pulse = ps_to_timer ? psc_out : base_expire;  // see (RQ17)
  assign tmod_tick     = ps_to_timer ? tmod_src_tick : psc_out;

  // ----------------------------------------------------------------
  // sleep, wake, reset and status control
  // ----------------------------------------------------------------
  sptw_pkg::sptw_state_t next_state;
  logic next_to_n;
  logic next_pdown_n;
  logic next_wake;
  logic next_wake_isr;
  logic next_expiry_reset;

  // master clear and our own reset request restart the block
  assign soft_rst  = !mclear_n_s || expiry_reset_pulse;
  assign core_halt = (state == sptw_pkg::st_sleep);

  // expiry outranks a same-cycle clear on the status bits
  always_comb begin
    next_state     = state;
    next_to_n      = timeout_status_n;  // see (RQ16)
    next_pdown_n      = powerdown_status_n;
    next_wake         = 1'b0;
    next_wake_isr     = 1'b0;
    next_expiry_reset = 1'b0;
    if (!mclear_n_s) begin
      next_state = sptw_pkg::st_run;
    end else begin
      case (state)
        sptw_pkg::st_run: begin
          if (timer_clear_instr) begin
            next_to_n    = 1'b1;
            next_pdown_n = 1'b1;
          end
          if (sleep_instr && !irq_pending) begin  // see (RQ9)
            next_to_n    = 1'b1;
            next_pdown_n = 1'b0;
            next_state = sptw_pkg::st_sleep;
          end
          if (timeout_pulse) begin
            next_to_n      = 1'b0;  // see (RQ8)
            next_expiry_reset = 1'b1;  // see (RQ2)
          end
        end
        sptw_pkg::st_sleep: begin
          if (timeout_pulse || irq_pending) begin
            next_wake     = 1'b1;  // see (RQ3) (RQ10)
            next_wake_isr = irq_pending && global_irq_enable;
            next_state    = sptw_pkg::st_run;
          end
          if (timeout_pulse) begin
            next_to_n = 1'b0;  // see (RQ8)
          end
        end
        default: next_state = sptw_pkg::st_run;
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      state              <= sptw_pkg::st_run;
      timeout_status_n   <= 1'b1;
      powerdown_status_n <= 1'b1;
      wake_pulse         <= 1'b0;
      wake_to_isr        <= 1'b0;
      expiry_reset_pulse <= 1'b0;
    end else begin
      state              <= next_state;
      timeout_status_n   <= next_to_n;
      powerdown_status_n <= next_pdown_n;
      wake_pulse         <= next_wake;
      wake_to_isr        <= next_wake_isr;
      expiry_reset_pulse <= next_expiry_reset;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);

  sequence run_expiry_s;
    state == sptw_pkg::st_run && timeout_pulse && mclear_n_s;
  endsequence

  sequence sleep_entry_s;
    state == sptw_pkg::st_run && sleep_instr && !irq_pending && mclear_n_s;
  endsequence

  fuse_off_quiet_a : assert property (!timer_enable |-> !timeout_pulse)  // see (RQ4)
    else $error("time-out raised while fuse disables timer");

  run_reset_req_a : assert property (  // see (RQ2)
    run_expiry_s |=> expiry_reset_pulse ##1 !expiry_reset_pulse)
    else $error("run expiry gave no single reset pulse");

  sleep_wake_a : assert property (  // see (RQ3)
    (core_halt && timeout_pulse && mclear_n_s)
    |=> (wake_pulse && !expiry_reset_pulse && !core_halt))
    else $error("sleep expiry did not wake cleanly");

  expiry_status_a : assert property (  // see (RQ8)
    (timeout_pulse && mclear_n_s) |=> !timeout_status_n)
    else $error("time-out bit not cleared on expiry");

  clear_zero_a : assert property (  // see (RQ7)
    (timer_clear_instr && !timeout_pulse && mclear_n_s) |=> (base_cnt == '0 && timeout_status_n))
    else $error("clear instruction left timer running");

  sleep_nop_a : assert property (  // see (RQ9)
    (state == sptw_pkg::st_run && sleep_instr && irq_pending && !timer_clear_instr)
    |=> (!core_halt && $stable(powerdown_status_n)))
    else $error("sleep with pending interrupt was not a no-op");

  sleep_enter_a : assert property (  // see (RQ10)
    sleep_entry_s ##1 (core_halt && irq_pending) |=> wake_pulse)
    else $error("interrupt right after sleep did not wake");

  sleep_status_a : assert property (  // see (RQ10)
    (sleep_entry_s and !timeout_pulse) |=> (!powerdown_status_n && timeout_status_n))
    else $error("sleep did not update power-down status");

  irq_wake_a : assert property ((core_halt && irq_pending && mclear_n_s) |=> wake_pulse)  // see (RQ11)
    else $error("enabled interrupt did not wake");

  cfg_guard_a : assert property ((cfg_rd_en && !prog_mode) |=> cfg_rdata == 14'h0000)  // see (RQ14)
    else $error("config space read outside programming mode");

  mclear_keep_a : assert property (  // see (RQ16)
    !mclear_n_s |=> ($stable(timeout_status_n) && $stable(powerdown_status_n)))
    else $error("master clear altered status bits");

endmodule : sptw_top

/* File: verification/sptw_core_model.sv */
// processor core stand-in that issues the clear and sleep instructions
`timescale 1ns/10ps

module sptw_core_model (
  // clock
  input  wire logic core_clk,
  // requests from the bench, halt state from the timer
  input  wire logic want_clear,
  input  wire logic want_sleep,
  input  wire logic core_halt,
  // instruction strobes toward the timer
  output logic      timer_clear_instr,
  output logic      sleep_instr
);
  logic sleep_due;

  // quiet strobes until the first request
  initial begin
    timer_clear_instr = 1'h0;
    sleep_instr = 1'h0;
    sleep_due = 1'h0;
  end

  // a halted core executes nothing; every sleep is led by a clear
  always @(posedge core_clk) begin
    timer_clear_instr <= !core_halt && (want_clear || want_sleep);
    sleep_due <= !core_halt && want_sleep;
    sleep_instr <= sleep_due;
  end
endmodule : sptw_core_model

/* File: verification/supervision_timer_sleep_wake_tb.sv */
// self-checking bench for the supervision timer top
`timescale 1ns/10ps

module supervision_timer_sleep_wake_tb;
  localparam int OSC = 4;
  localparam int TICKS = 20;
  localparam int LO = (TICKS - 1) * OSC - 2;
  localparam int HI = TICKS * OSC + 4;

  typedef struct {
    logic [2:0]  k;
    logic [13:0] a;
    logic [13:0] d;
    logic [13:0] e;
  } sptw_row_t;

  logic        core_clk, reset, master_clear_n, prog_mode_pin;
  logic        want_clear, want_sleep, timer_clear_instr, sleep_instr;
  logic [3:0]  irq_enable, irq_flag;
  logic        global_irq_enable, reg_wr_en, cfg_rd_en, cfg_wr_en;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, option_value;
  logic [13:0] cfg_addr, cfg_wdata, cfg_rdata, q;
  logic        tmod_src_tick, tmod_tick, timeout_status_n, powerdown_status_n;
  logic        core_halt, wake_pulse, wake_to_isr, expiry_reset_pulse;
  int          bad_count = 0;
  int          checked = 0;
  int          n;

  // k is {config port, programming mode, write first}
  sptw_row_t rows [8] = '{
    '{3'h1, 14'h0081, 14'h005a, 14'h005a}, '{3'h1, 14'h0080, 14'h0011, 14'h0000},
    '{3'h4, 14'h2007, 14'h0000, 14'h0000}, '{3'h6, 14'h2007, 14'h0000, 14'h3fff},
    '{3'h5, 14'h2007, 14'h0000, 14'h0000}, '{3'h6, 14'h2007, 14'h0000, 14'h3fff},
    '{3'h6, 14'h1fff, 14'h0000, 14'h0000}, '{3'h7, 14'h2006, 14'h0000, 14'h0000}};

  // 250 MHz core clock
  initial begin
    core_clk = 1'h0;
    forever #2 core_clk = ~core_clk;
  end

  sptw_top #(.OSC_CYCLES(OSC), .TIMEOUT_TICKS(TICKS)) sptw_top_inst (
    .core_clk, .reset, .master_clear_n, .prog_mode_pin, .timer_clear_instr,
    .sleep_instr, .irq_enable, .irq_flag, .global_irq_enable, .reg_wr_en,
    .reg_addr, .reg_wdata, .reg_rdata, .option_value, .cfg_rd_en, .cfg_wr_en,
    .cfg_addr, .cfg_wdata, .cfg_rdata, .tmod_src_tick, .tmod_tick,
    .timeout_status_n, .powerdown_status_n, .core_halt, .wake_pulse,
    .wake_to_isr, .expiry_reset_pulse);

  sptw_core_model sptw_core_model_inst (
    .core_clk, .want_clear, .want_sleep, .core_halt, .timer_clear_instr,
    .sleep_instr);

  // ----
  // tasks
  // ----
  task automatic chk(input string nm, input logic [13:0] e, input logic [13:0] g);
    checked++;
    if (g !== e) begin
      $display("FAIL %s expected %h seen %h", nm, e, g);
      bad_count++;
    end
  endtask : chk

  // one strobe cycle; rdata is registered, so it is taken one cycle on
  task automatic acc(input logic c, input logic w, input logic [13:0] a,
                     input logic [13:0] d, output logic [13:0] r);
    @(negedge core_clk);
    if (c) begin
      {cfg_wr_en, cfg_rd_en, cfg_addr, cfg_wdata} = {w, !w, a, d};
    end else begin
      {reg_wr_en, reg_addr, reg_wdata} = {w, a[7:0], d[7:0]};
    end
    @(negedge core_clk);
    {cfg_wr_en, cfg_rd_en, reg_wr_en} = 3'h0;
    r = c ? cfg_rdata : {6'h00, reg_rdata};
  endtask : acc

  task automatic issue(input logic c, input logic s);
    @(negedge core_clk);
    {want_clear, want_sleep} = {c, s};
    @(negedge core_clk);
    {want_clear, want_sleep} = 2'h0;
  endtask : issue

  // bounded wait; n comes back equal to lim when nothing showed
  task automatic wait_hi(ref logic s, input int lim, output int cnt);
    cnt = 0;
    while (s !== 1'h1 && cnt < lim) begin
      @(negedge core_clk);
      cnt++;
    end
  endtask : wait_hi

  task automatic summarize();
    if (bad_count == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : summarize

  // ----
  // main sequence
  // ----
  initial begin
    {reset, master_clear_n} = 2'h3;
    {prog_mode_pin, want_clear, want_sleep, irq_enable, irq_flag} = '0;
    {global_irq_enable, reg_wr_en, cfg_rd_en, cfg_wr_en, tmod_src_tick} = '0;
    {reg_addr, reg_wdata, cfg_addr, cfg_wdata} = '0;
    repeat (2) @(negedge core_clk);
    reset = 1'h0;
    chk("option", 14'h00ff, option_value);
    chk("to_n", 14'h1, timeout_status_n);
    chk("pdown_n", 14'h1, powerdown_status_n);
    foreach (rows[i]) begin
      prog_mode_pin = rows[i].k[1];
      repeat (3) @(negedge core_clk);
      if (rows[i].k[0]) acc(rows[i].k[2], 1'h1, rows[i].a, rows[i].d, q);
      acc(rows[i].k[2], 1'h0, rows[i].a, 14'h0000, q);
      chk("access", rows[i].e, q);
    end
    // run-mode expiry, then a master clear that keeps the status bits
    prog_mode_pin = 1'h0;
    acc(1'h0, 1'h1, 14'h0081, 14'h0008, q);
    issue(1'h1, 1'h0);
    wait_hi(expiry_reset_pulse, 400, n);
    chk("expiry", 14'h1, 14'(n >= LO && n <= HI));
    chk("to_n", 14'h0, timeout_status_n);
    @(negedge core_clk);
    chk("pulse", 14'h0, expiry_reset_pulse);
    chk("option", 14'h00ff, option_value);
    acc(1'h0, 1'h1, 14'h0081, 14'h0008, q);
    master_clear_n = 1'h0;
    repeat (3) @(negedge core_clk);
    master_clear_n = 1'h1;
    repeat (3) @(negedge core_clk);
    chk("to_n", 14'h0, timeout_status_n);
    chk("option", 14'h00ff, option_value);
    // prescaler 1:2 doubles the time-out
    acc(1'h0, 1'h1, 14'h0081, 14'h0009, q);
    issue(1'h1, 1'h0);
    wait_hi(expiry_reset_pulse, 400, n);
    chk("ps_expiry", 14'h1, 14'(n >= 2 * LO && n <= 2 * HI));
    // steady clears hold the reset off
    acc(1'h0, 1'h1, 14'h0081, 14'h0008, q);
    repeat (6) begin
      issue(1'h1, 1'h0);
      wait_hi(expiry_reset_pulse, 50, n);
      chk("no_expiry", 14'h32, 14'(n));
    end
    // prescaler handed to the timer module at 1:2
    acc(1'h0, 1'h1, 14'h0081, 14'h0000, q);
    issue(1'h1, 1'h0);
    tmod_src_tick = 1'h1;
    n = 0;
    repeat (16) begin
      @(negedge core_clk);
      n += int'(tmod_tick === 1'h1);
    end
    tmod_src_tick = 1'h0;
    chk("tmod_ticks", 14'h8, 14'(n));
    // sleep, then the expiry wakes instead of resetting
    acc(1'h0, 1'h1, 14'h0081, 14'h0008, q);
    issue(1'h0, 1'h1);
    repeat (2) @(negedge core_clk);
    chk("halt", 14'h1, core_halt);
    chk("pdown_n", 14'h0, powerdown_status_n);
    chk("to_n", 14'h1, timeout_status_n);
    wait_hi(wake_pulse, 400, n);
    chk("wake", 14'h1, 14'(n >= LO - 2 && n <= HI));
    chk("pulse", 14'h0, expiry_reset_pulse);
    chk("to_n", 14'h0, timeout_status_n);
    // pending interrupt turns sleep into a no-operation
    {irq_enable, irq_flag} = 8'h11;
    issue(1'h0, 1'h1);
    repeat (3) @(negedge core_clk);
    chk("halt", 14'h0, core_halt);
    chk("pdown_n", 14'h1, powerdown_status_n);
    // interrupt during sleep wakes whatever the global enable says
    for (int g = 0; g < 2; g++) begin
      irq_flag = 4'h0;
      global_irq_enable = g[0];
      issue(1'h0, 1'h1);
      repeat (4) @(negedge core_clk);
      irq_flag = 4'h1;
      wait_hi(wake_pulse, 4, n);
      chk("irq_wake", 14'h1, 14'(n < 4));
      chk("to_isr", 14'(g), wake_to_isr);
    end
    irq_flag = 4'h0;
    // programmed fuse stops all expiry
    prog_mode_pin = 1'h1;
    repeat (3) @(negedge core_clk);
    acc(1'h1, 1'h1, 14'h2007, 14'h3ffb, q);
    acc(1'h1, 1'h0, 14'h2007, 14'h0000, q);
    chk("cfg", 14'h3ffb, q);
    prog_mode_pin = 1'h0;
    acc(1'h0, 1'h1, 14'h0081, 14'h0008, q);
    issue(1'h1, 1'h0);
    wait_hi(expiry_reset_pulse, 200, n);
    chk("disabled", 14'hc8, 14'(n));
    summarize();
  end

  // hang guard, far beyond the thousand or so cycles the tests need
  initial begin
    repeat (20000) @(posedge core_clk);
    bad_count++;
    summarize();
  end
endmodule : supervision_timer_sleep_wake_tb
